// ==== inc/bdr_pkg.sv ====
// bdr_pkg: register map, field positions, reset values and carrier types
// for the bridge driver diagnostic, mask and control register bank.
// assumes a 16-bit serial word: address 15:12, write flag 11, data 10:1, parity 0.
package bdr_pkg;
  // word layout
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 12;
  localparam int WR_BIT = 11;
  localparam int DATA_HI = 10;
  localparam int DATA_LO = 1;
  localparam int PAR_BIT = 0;
  localparam int DATA_W = 10;

  // register addresses (printed index)
  localparam logic [3:0] ADR_VERIFY_LOW = 4'h8;
  localparam logic [3:0] ADR_VERIFY_HIGH = 4'h9;
  localparam logic [3:0] ADR_MASK_GATE_UV = 4'hA;
  localparam logic [3:0] ADR_MASK_DRAIN_OV = 4'hB;
  localparam logic [3:0] ADR_FLAGS_GATE_UV = 4'hC;
  localparam logic [3:0] ADR_FLAGS_DRAIN_OV = 4'hD;
  localparam logic [3:0] ADR_FLAGS_SUPPLY = 4'hE;
  localparam logic [3:0] ADR_CONTROL = 4'hF;

  // field positions inside the 10-bit data field (word bit minus one)
  localparam int F_HI_A = 9; // word bit 10
  localparam int F_HI_B = 8; // word bit 9
  localparam int F_MID_A = 7; // word bit 8
  localparam int F_MID_B = 6; // word bit 7
  localparam int F_PH_B = 5; // word bit 6
  localparam int F_PH_A = 4; // word bit 5
  localparam int F_Q3 = 3; // word bit 4
  localparam int F_Q2 = 2; // word bit 3
  localparam int F_Q1 = 1; // word bit 2
  localparam int F_Q0 = 0; // word bit 1

  // writable bit masks per register
  localparam logic [9:0] MASK_WR_BITS = 10'h3CF;
  localparam logic [9:0] CTRL_WR_BITS = 10'h3CF;
  localparam logic [9:0] MASK_RESET = 10'h000;
  localparam logic [9:0] CTRL_RESET = 10'h040; // stop on fault set

  // fault pin source encodings
  localparam logic [1:0] PIN_FAULT_N = 2'h0;
  localparam logic [1:0] PIN_PULSE = 2'h1;
  localparam logic [1:0] PIN_TEMP = 2'h2;
  localparam logic [1:0] PIN_SENSE = 2'h3;

  // raw detector levels from the analog comparators
  typedef struct packed {
    logic aux3_overvoltage;
    logic aux3_undervoltage;
    logic bootstrap_uv; // any phase, unused; the mask gate acts on the per-phase bits
    logic temp_warning;
    logic [3:0] gate_uv; // b_high, b_low, a_high, a_low
    logic regulator_overvoltage;
    logic regulator_undervoltage;
    logic logic_overvoltage;
    logic [3:0] drain_ov; // b_high, b_low, a_high, a_low
    logic supply_overvoltage;
    logic supply_undervoltage;
    logic b_bootstrap_uv;
    logic a_bootstrap_uv;
    logic b_overcurrent;
    logic a_overcurrent;
    logic load_open_fault;
  } bdr_fault_raw_t;

  // verification results from the verify engine (same clock)
  typedef struct packed {
    logic phase_b_connect_result;
    logic phase_a_connect_result;
    logic bridge_supply_disconnect_result;
    logic low_sense_b_disconnect_result;
    logic low_sense_a_disconnect_result;
    logic phase_b_state_result;
    logic phase_a_state_result;
    logic amp_b_disconnect_result;
    logic amp_a_disconnect_result;
  } bdr_verify_t;

  // summary status toward the status register
  typedef struct packed {
    logic load_fault_summary;
    logic gate_uv_summary;
    logic drain_ov_summary;
    logic bootstrap_uv;
    logic supply_range;
    logic regulator_range;
    logic aux3_range;
    logic temp_warning;
    logic logic_overvoltage;
  } bdr_summary_t;
endpackage

// ==== rtl/bdr_regs.sv ====
// bdr_regs: diagnostic, mask and control register bank of the bridge driver.
// assumes a serial framer on ref_clk_i hands over each received 16-bit word
// as a one-cycle strobe and shifts out the answer word on the next frame.
// Operation
// - every word carries an odd-parity bit at bit 0, checked on receive and made on reply.
// - verify result low is read-only with the five connect and disconnect results, reset 0.
// - verify result high is read-only with the two phase states and two amplifier results, reset 0.
// - gate undervoltage mask holds four gate fault disables, 0 permits, 1 disables, reset 0.
// - the same mask also disables aux rail over and under voltage, bootstrap and temperature.
// - drain overvoltage mask holds four drain fault disables, 0 permits, 1 disables, reset 0.
// - the same mask also disables regulator over and under, supply range and logic overvoltage.
// - first flag register is read-only with aux rail and four gate undervoltage faults, reset 0.
// - second flag register is read-only with regulator and four drain overvoltage faults.
// - third flag register is read-only with supply, bootstrap, overcurrent and open load faults.
// - a two-bit field picks the fault pin source while the strobe is high, default low-true fault.
// - a control bit set to 1 disables the bootstrap manager, default 0.
// - stop on fault resets to 1; at 1 a load, gate or drain fault stops the bridge, at 0 it is only reported.
// - four gate command bits for both phases, high and low side, reset 0.
// - summary bits are formed from the detailed flags: load, gate and drain groups.
`timescale 1ns/1ps
module bdr_regs #(
  parameter int PULSE_CYC = 16 // half period of the pulsed fault pin, in cycles
) (
  input wire logic ref_clk_i, // 40 MHz device clock
  input wire logic reset_i, // synchronous, active high
  input wire logic word_valid_i, // one-cycle strobe, received word ready
  input wire logic [15:0] word_i, // received serial word
  output logic reply_valid_o, // one-cycle strobe, reply word loaded
  output logic [15:0] reply_o, // reply word with odd parity
  output logic parity_error_o, // one-cycle pulse on a bad-parity word
  input wire bdr_pkg::bdr_fault_raw_t fault_raw_i, // async detector levels
  input wire bdr_pkg::bdr_verify_t verify_i, // verify engine results
  input wire logic serial_strobe_n_i, // serial strobe pin, async
  input wire logic [3:0] gate_cmd_pin_i, // direct logic inputs, async, active high
  output logic [3:0] gate_drive_o, // gate demand: b_hi, b_lo, a_hi, a_lo
  output logic bridge_stop_o, // bridge held off by a fault
  output logic bootstrap_mgr_en_o, // bootstrap manager active
  output logic [1:0] fault_pin_source_select_o, // source field for the pin mux
  output logic diag_pin_o, // digital level for the fault pin
  output logic diag_pin_oe_o, // high while the block drives the fault pin
  output bdr_pkg::bdr_summary_t summary_o // summary flags for status
);
  localparam int PCNT_W = $clog2(PULSE_CYC + 1);

  // two-flop synchronisers for everything from pins and analog
  bdr_pkg::bdr_fault_raw_t fault_s1_q, fault_s2_q;
  logic strobe_s1_q, strobe_s2_q;
  logic [3:0] pin_s1_q, pin_s2_q;

  // no reset on these flops; the ten-cycle reset hold flushes them
  always_ff @(posedge ref_clk_i)
  begin
    fault_s1_q <= fault_raw_i;
    fault_s2_q <= fault_s1_q;
    strobe_s1_q <= serial_strobe_n_i;
    strobe_s2_q <= strobe_s1_q;
    pin_s1_q <= gate_cmd_pin_i;
    pin_s2_q <= pin_s1_q;
  end

  // word decode
  wire logic [3:0] w_addr = word_i[bdr_pkg::ADDR_HI:bdr_pkg::ADDR_LO];
  wire logic w_wr = word_i[bdr_pkg::WR_BIT];
  wire logic [9:0] w_data = word_i[bdr_pkg::DATA_HI:bdr_pkg::DATA_LO];
  wire logic parity_ok = ^word_i;
  wire logic take = word_valid_i && parity_ok;
  wire logic do_wr = take && w_wr;

  // address hits, one per register that has state in this bank
  wire logic hit_mask0 = w_addr == bdr_pkg::ADR_MASK_GATE_UV;
  wire logic hit_mask1 = w_addr == bdr_pkg::ADR_MASK_DRAIN_OV;
  wire logic hit_ctrl = w_addr == bdr_pkg::ADR_CONTROL;
  wire logic hit_flag0 = w_addr == bdr_pkg::ADR_FLAGS_GATE_UV;
  wire logic hit_flag1 = w_addr == bdr_pkg::ADR_FLAGS_DRAIN_OV;
  wire logic hit_flag2 = w_addr == bdr_pkg::ADR_FLAGS_SUPPLY;

  // writable registers; read-only addresses never reach them
  logic [9:0] mask0_q, mask1_q, ctrl_q;
  wire logic [9:0] mask0_d = (w_data & bdr_pkg::MASK_WR_BITS) | (mask0_q & ~bdr_pkg::MASK_WR_BITS);
  wire logic [9:0] mask1_d = (w_data & bdr_pkg::MASK_WR_BITS) | (mask1_q & ~bdr_pkg::MASK_WR_BITS);
  wire logic [9:0] ctrl_d = (w_data & bdr_pkg::CTRL_WR_BITS) | (ctrl_q & ~bdr_pkg::CTRL_WR_BITS);

  // register update; a bad-parity word never gets here, so it cannot write
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      mask0_q <= bdr_pkg::MASK_RESET;
      mask1_q <= bdr_pkg::MASK_RESET;
      ctrl_q <= bdr_pkg::CTRL_RESET;
    end
    else
    begin
      if (do_wr && hit_mask0)
        mask0_q <= mask0_d;
      if (do_wr && hit_mask1)
        mask1_q <= mask1_d;
      if (do_wr && hit_ctrl)
        ctrl_q <= ctrl_d;
    end
  end

  // control fields
  wire logic [1:0] pin_sel = ctrl_q[bdr_pkg::F_HI_A:bdr_pkg::F_HI_B];
  wire logic bsm_dis = ctrl_q[bdr_pkg::F_MID_A];
  wire logic stop_en = ctrl_q[bdr_pkg::F_MID_B];
  wire logic [3:0] ser_cmd = ctrl_q[bdr_pkg::F_Q3:bdr_pkg::F_Q0];

  // masked fault events; a set mask bit blocks the fault everywhere
  wire logic [3:0] gate_uv_m = fault_s2_q.gate_uv & ~mask0_q[bdr_pkg::F_Q3:bdr_pkg::F_Q0];
  wire logic aux_ov_m = fault_s2_q.aux3_overvoltage & ~mask0_q[bdr_pkg::F_HI_A];
  wire logic aux_uv_m = fault_s2_q.aux3_undervoltage & ~mask0_q[bdr_pkg::F_HI_B];
  wire logic bsu_en = ~mask0_q[bdr_pkg::F_MID_A];
  wire logic temp_m = fault_s2_q.temp_warning & ~mask0_q[bdr_pkg::F_MID_B];

  // drain mask register gates drain, regulator and logic supply faults
  wire logic [3:0] drain_ov_m = fault_s2_q.drain_ov & ~mask1_q[bdr_pkg::F_Q3:bdr_pkg::F_Q0];
  wire logic reg_ov_m = fault_s2_q.regulator_overvoltage & ~mask1_q[bdr_pkg::F_HI_A];
  wire logic reg_uv_m = fault_s2_q.regulator_undervoltage & ~mask1_q[bdr_pkg::F_HI_B];
  wire logic range_en = ~mask1_q[bdr_pkg::F_MID_A];
  wire logic lov_m = fault_s2_q.logic_overvoltage & ~mask1_q[bdr_pkg::F_MID_B];

  // one mask bit covers two detectors; overcurrent and open load stay unmasked
  wire logic sup_ov_m = fault_s2_q.supply_overvoltage & range_en;
  wire logic sup_uv_m = fault_s2_q.supply_undervoltage & range_en;
  wire logic b_bsu_m = fault_s2_q.b_bootstrap_uv & bsu_en;
  wire logic a_bsu_m = fault_s2_q.a_bootstrap_uv & bsu_en;

  // set vectors laid out as the flag registers read
  logic [9:0] set0, set1, set2;
  always_comb
  begin
    // first flags: aux rail and gate undervoltage
    set0 = '0;
    set0[bdr_pkg::F_HI_A] = aux_ov_m;
    set0[bdr_pkg::F_HI_B] = aux_uv_m;
    set0[bdr_pkg::F_Q3:bdr_pkg::F_Q0] = gate_uv_m;
    // second flags: regulator and drain overvoltage
    set1 = '0;
    set1[bdr_pkg::F_HI_A] = reg_ov_m;
    set1[bdr_pkg::F_HI_B] = reg_uv_m;
    set1[bdr_pkg::F_Q3:bdr_pkg::F_Q0] = drain_ov_m;
    // third flags: supply, bootstrap and load faults
    set2 = '0;
    set2[bdr_pkg::F_HI_A] = sup_ov_m;
    set2[bdr_pkg::F_HI_B] = sup_uv_m;
    set2[bdr_pkg::F_MID_B] = b_bsu_m;
    set2[bdr_pkg::F_PH_B] = a_bsu_m;
    set2[bdr_pkg::F_Q2] = fault_s2_q.b_overcurrent;
    set2[bdr_pkg::F_Q1] = fault_s2_q.a_overcurrent;
    set2[bdr_pkg::F_Q0] = fault_s2_q.load_open_fault;
  end

  // sticky flags, cleared by a read of their register; a fault still
  // present in the clearing cycle sets the bit again, so none is lost
  logic [9:0] flag0_q, flag1_q, flag2_q;
  wire logic rd_clr0 = take && !w_wr && hit_flag0;
  wire logic rd_clr1 = take && !w_wr && hit_flag1;
  wire logic rd_clr2 = take && !w_wr && hit_flag2;

  // a word with the write flag set reads the flags but leaves them alone
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      flag0_q <= '0;
      flag1_q <= '0;
      flag2_q <= '0;
    end
    else
    begin
      flag0_q <= (rd_clr0 ? '0 : flag0_q) | set0;
      flag1_q <= (rd_clr1 ? '0 : flag1_q) | set1;
      flag2_q <= (rd_clr2 ? '0 : flag2_q) | set2;
    end
  end

  // summaries built from the latched detailed flags
  wire logic load_sum = |flag2_q[bdr_pkg::F_Q2:bdr_pkg::F_Q0];
  wire logic gate_sum = |flag0_q[bdr_pkg::F_Q3:bdr_pkg::F_Q0];
  wire logic drain_sum = |flag1_q[bdr_pkg::F_Q3:bdr_pkg::F_Q0];
  wire logic bsu = flag2_q[bdr_pkg::F_MID_B] | flag2_q[bdr_pkg::F_PH_B];

  // any latched flag or live warning counts for the fault pin
  wire logic any_fault = load_sum | gate_sum | drain_sum | bsu | temp_m | lov_m |
    (|flag0_q) | (|flag1_q) | (|flag2_q);

  // stop on fault: bridge faults only, and only while enabled
  wire logic stop_now = stop_en && (load_sum || gate_sum || drain_sum);

  // serial commands and direct pins merge; either side can turn a gate on
  wire logic [3:0] cmd_mix = ser_cmd | pin_s2_q;

  // verify result words
  logic [9:0] vres0, vres1;
  always_comb
  begin
    // low word: connect and disconnect results, data bit 2 unused
    vres0 = '0;
    vres0[bdr_pkg::F_PH_B] = verify_i.phase_b_connect_result;
    vres0[bdr_pkg::F_PH_A] = verify_i.phase_a_connect_result;
    vres0[bdr_pkg::F_Q3] = verify_i.bridge_supply_disconnect_result;
    vres0[bdr_pkg::F_Q1] = verify_i.low_sense_b_disconnect_result;
    vres0[bdr_pkg::F_Q0] = verify_i.low_sense_a_disconnect_result;
    // high word: phase states and amplifier results, data bit 2 unused
    vres1 = '0;
    vres1[bdr_pkg::F_PH_A] = verify_i.phase_b_state_result;
    vres1[bdr_pkg::F_Q3] = verify_i.phase_a_state_result;
    vres1[bdr_pkg::F_Q1] = verify_i.amp_b_disconnect_result;
    vres1[bdr_pkg::F_Q0] = verify_i.amp_a_disconnect_result;
  end

  // read data select; addresses outside this bank answer zero data
  wire logic [9:0] rd_data =
    (w_addr == bdr_pkg::ADR_VERIFY_LOW) ? vres0 :
    (w_addr == bdr_pkg::ADR_VERIFY_HIGH) ? vres1 :
    hit_mask0 ? mask0_q :
    hit_mask1 ? mask1_q :
    hit_flag0 ? flag0_q :
    hit_flag1 ? flag1_q :
    hit_flag2 ? flag2_q :
    hit_ctrl ? ctrl_q : '0;

  // reply carries the address back with the write flag cleared
  wire logic [14:0] reply_body = {w_addr, 1'b0, rd_data};
  wire logic [15:0] reply_d = {reply_body, ~(^reply_body)};

  // reply word, sampled before the write lands so a write echoes old data
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      reply_o <= '0;
      reply_valid_o <= 1'b0;
      parity_error_o <= 1'b0;
    end
    else
    begin
      reply_valid_o <= take;
      parity_error_o <= word_valid_i && !parity_ok;
      if (take)
        reply_o <= reply_d;
    end
  end

  // pulse-fault timebase: one-cycle enable every PULSE_CYC cycles
  logic [PCNT_W-1:0] pcnt_q;
  logic pulse_q;
  wire logic pulse_tick = pcnt_q == PCNT_W'(PULSE_CYC - 1);
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      pcnt_q <= '0;
      pulse_q <= 1'b0;
    end
    else
    begin
      pcnt_q <= pulse_tick ? '0 : pcnt_q + PCNT_W'(1);
      if (pulse_tick)
        pulse_q <= any_fault ? ~pulse_q : 1'b0;
    end
  end

  // fault pin mux; the sense path is analog, so the digital level rests low
  wire logic pin_level =
    (pin_sel == bdr_pkg::PIN_FAULT_N) ? ~any_fault :
    (pin_sel == bdr_pkg::PIN_PULSE) ? pulse_q :
    (pin_sel == bdr_pkg::PIN_TEMP) ? temp_m : 1'b0;

  // registered outputs
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      gate_drive_o <= '0;
      bridge_stop_o <= 1'b0;
      bootstrap_mgr_en_o <= 1'b1;
      fault_pin_source_select_o <= bdr_pkg::PIN_FAULT_N;
      diag_pin_o <= 1'b1;
      diag_pin_oe_o <= 1'b0;
      summary_o <= '0;
    end
    else
    begin
      gate_drive_o <= stop_now ? 4'h0 : cmd_mix;
      bridge_stop_o <= stop_now;
      bootstrap_mgr_en_o <= ~bsm_dis;
      fault_pin_source_select_o <= pin_sel;
      diag_pin_o <= pin_level;
      diag_pin_oe_o <= strobe_s2_q;
      // summary levels trail the latched flags and the live warnings by one cycle
      summary_o.load_fault_summary <= load_sum;
      summary_o.gate_uv_summary <= gate_sum;
      summary_o.drain_ov_summary <= drain_sum;
      summary_o.bootstrap_uv <= bsu;
      summary_o.supply_range <= |flag2_q[bdr_pkg::F_HI_A:bdr_pkg::F_HI_B];
      summary_o.regulator_range <= |flag1_q[bdr_pkg::F_HI_A:bdr_pkg::F_HI_B];
      summary_o.aux3_range <= |flag0_q[bdr_pkg::F_HI_A:bdr_pkg::F_HI_B];
      summary_o.temp_warning <= temp_m;
      summary_o.logic_overvoltage <= lov_m;
    end
  end
endmodule // bdr_regs

// ==== tb/bdr_props.sv ====
// bdr_props: port checks on the register bank's serial words and outputs.
// assumes the bdr_regs ports; bound to every instance at the foot of this file.
`timescale 1ns/1ps
module bdr_props #(
  parameter int PULSE_CYC = 16 // pulse half period, kept for the bind
) (
  input wire logic ref_clk_i, // device clock
  input wire logic reset_i, // synchronous reset
  input wire logic word_valid_i, // word strobe
  input wire logic [15:0] word_i, // received word
  input wire logic reply_valid_o, // reply strobe
  input wire logic [15:0] reply_o, // reply word
  input wire logic parity_error_o, // refusal pulse
  input wire bdr_pkg::bdr_verify_t verify_i, // verify results
  input wire logic serial_strobe_n_i, // strobe pin
  input wire logic [3:0] gate_drive_o, // gate demand
  input wire logic bridge_stop_o, // bridge stop
  input wire logic [1:0] fault_pin_source_select_o, // pin source
  input wire logic diag_pin_oe_o // pin enable
);
  logic [9:0] vlow;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // expected data field of the low verify register
  assign vlow = {4'h0, verify_i.phase_b_connect_result, verify_i.phase_a_connect_result,
    verify_i.bridge_supply_disconnect_result, 1'b0, verify_i.low_sense_b_disconnect_result,
    verify_i.low_sense_a_disconnect_result};
  // words with odd and with even parity on their strobe edge
  sequence s_good;
    word_valid_i && (^word_i);
  endsequence
  sequence s_bad;
    word_valid_i && !(^word_i);
  endsequence
  a_reply_odd_parity: assert property (reply_valid_o |-> ^reply_o)
    else $error("reply word has even parity");
  a_bad_word_refused: assert property (s_bad |=> parity_error_o && !reply_valid_o)
    else $error("even parity word not refused");
  a_good_word_answered: assert property (s_good |=> reply_valid_o && !parity_error_o && !reply_o[11]
    && reply_o[15:12] == $past(word_i[15:12])) else $error("good word answered wrongly");
  a_reply_holds: assert property (!reply_valid_o |-> $stable(reply_o))
    else $error("reply word moved without a strobe");
  a_unmapped_zero: assert property (s_good ##0 !word_i[15] |=> reply_o[10:1] == 10'h000)
    else $error("unmapped address gave data");
  a_verify_low_read: assert property (s_good ##0 word_i[15:12] == 4'h8 |=> reply_o[10:1] == $past(vlow))
    else $error("verify low data wrong");
  a_stop_blocks_gates: assert property (bridge_stop_o |-> gate_drive_o == 4'h0)
    else $error("gates driven while stopped");
  a_source_after_write: assert property ($changed(fault_pin_source_select_o) |->
    $past(word_valid_i) || $past(word_valid_i, 2)) else $error("pin source moved without a word");
  a_oe_follows_strobe: assert property (serial_strobe_n_i [*5] |-> diag_pin_oe_o)
    else $error("fault pin not driven with strobe high");
endmodule // bdr_props
bind bdr_regs bdr_props #(.PULSE_CYC(PULSE_CYC)) i_props (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
  .word_valid_i(word_valid_i), .word_i(word_i), .reply_valid_o(reply_valid_o), .reply_o(reply_o),
  .parity_error_o(parity_error_o), .verify_i(verify_i), .serial_strobe_n_i(serial_strobe_n_i),
  .gate_drive_o(gate_drive_o), .bridge_stop_o(bridge_stop_o),
  .fault_pin_source_select_o(fault_pin_source_select_o), .diag_pin_oe_o(diag_pin_oe_o));

// ==== tb/bdr_host.sv ====
// bdr_host: serial master model framing whole words for the register bank.
// assumes the framer contract: one-cycle word strobe, reply one cycle later.
`timescale 1ns/1ps
module bdr_host (
  input wire logic ref_clk_i, // device clock
  output logic word_valid_o, // word strobe
  output logic [15:0] word_o, // framed word
  input wire logic reply_valid_i, // reply strobe
  input wire logic [15:0] reply_i, // reply word
  input wire logic parity_error_i // refusal pulse
);
  // idle bus at time zero
  initial
  begin
    word_valid_o = 1'b0;
    word_o = 16'h0000;
  end
  // one transfer; bad flips the parity to provoke a refusal
  task automatic xfer(input logic [3:0] a, input logic wr, input logic [9:0] d, input logic bad,
    output logic [15:0] r, output logic ok, output logic pe);
    @(posedge ref_clk_i);
    word_valid_o <= 1'b1;
    word_o <= {a, wr, d, ~^{a, wr, d} ^ bad};
    @(posedge ref_clk_i);
    word_valid_o <= 1'b0;
    word_o <= ~word_o; // released word never shows its last value
    #1;
    r = reply_i;
    ok = reply_valid_i;
    pe = parity_error_i;
  endtask
endmodule // bdr_host

// ==== tb/tb_top.sv ====
// tb_top: register bank bench driving words through the host model.
// assumes bdr_regs with a short pulse period and a fixed reply latency.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wv, rv, pe_o, stop, mgr, dpin, doe, ok, pe, p;
  logic [15:0] word, reply, r;
  logic [3:0] gcmd = 4'h0;
  logic [3:0] gate;
  logic [1:0] sel;
  logic [9:0] c = 10'h040;
  logic strobe_n = 1'b0;
  bdr_pkg::bdr_fault_raw_t fraw = '0;
  bdr_pkg::bdr_verify_t ver = '0;
  bdr_pkg::bdr_summary_t summ;
  int n_mismatch = 0;
  int n_tests = 0;
  // 40 MHz clock
  always #12.5 ref_clk_i = ~ref_clk_i;
  bdr_regs #(.PULSE_CYC(2)) i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .word_valid_i(wv),
    .word_i(word), .reply_valid_o(rv), .reply_o(reply), .parity_error_o(pe_o), .fault_raw_i(fraw),
    .verify_i(ver), .serial_strobe_n_i(strobe_n), .gate_cmd_pin_i(gcmd), .gate_drive_o(gate),
    .bridge_stop_o(stop), .bootstrap_mgr_en_o(mgr), .fault_pin_source_select_o(sel),
    .diag_pin_o(dpin), .diag_pin_oe_o(doe), .summary_o(summ));
  bdr_host i_host (.ref_clk_i(ref_clk_i), .word_valid_o(wv), .word_o(word), .reply_valid_i(rv),
    .reply_i(reply), .parity_error_i(pe_o));
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one access; the reply echoes the data held before any write
  task automatic acc(input logic [3:0] a, input logic wr, input logic [9:0] d, input logic [9:0] e);
    i_host.xfer(a, wr, d, 1'b0, r, ok, pe);
    chk({14'h0, ok, pe}, 16'h0002);
    chk(r, {a, 1'b0, e, ~^{a, e}});
  endtask
  // let synchronised detector levels settle, then look at the outputs
  task automatic settle();
    repeat (6) @(posedge ref_clk_i);
    #1;
  endtask
  // hang guard
  initial
  begin
    #100us;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    strobe_n <= 1'b1;
    for (int a = 8; a < 16; a++)
      acc(a[3:0], 1'b0, 10'h000, (a == 15) ? 10'h040 : 10'h000);
    acc(4'h3, 1'b1, 10'h3FF, 10'h000);
    @(posedge ref_clk_i);
    ver <= '1;
    acc(4'h8, 1'b1, 10'h000, 10'h03B);
    acc(4'h9, 1'b0, 10'h000, 10'h01B);
    acc(4'hA, 1'b1, 10'h3FF, 10'h000);
    acc(4'hB, 1'b1, 10'h3FF, 10'h000);
    i_host.xfer(4'hA, 1'b1, 10'h000, 1'b1, r, ok, pe);
    chk({14'h0, ok, pe}, 16'h0001);
    acc(4'hA, 1'b0, 10'h000, 10'h3CF);
    acc(4'hB, 1'b0, 10'h000, 10'h3CF);
    @(posedge ref_clk_i);
    fraw <= '1;
    settle();
    chk({7'h0, summ}, 16'h0100);
    chk({11'h0, stop, gate}, 16'h0010);
    acc(4'hC, 1'b0, 10'h000, 10'h000);
    acc(4'hD, 1'b0, 10'h000, 10'h000);
    acc(4'hE, 1'b1, 10'h3FF, 10'h007);
    acc(4'hA, 1'b1, 10'h000, 10'h3CF);
    acc(4'hB, 1'b1, 10'h000, 10'h3CF);
    settle();
    chk({7'h0, summ}, 16'h01FF);
    acc(4'hC, 1'b0, 10'h000, 10'h30F);
    acc(4'hD, 1'b0, 10'h000, 10'h30F);
    acc(4'hE, 1'b0, 10'h000, 10'h367);
    @(posedge ref_clk_i);
    fraw <= '0;
    settle();
    for (int a = 12; a < 15; a++)
      acc(a[3:0], 1'b0, 10'h000, (a == 14) ? 10'h367 : 10'h30F);
    acc(4'hC, 1'b0, 10'h000, 10'h000);
    // every pin source code, bootstrap disable and one gate command each
    for (int i = 0; i < 4; i++)
    begin
      acc(4'hF, 1'b1, {i[1:0], i[0], 3'b000, 4'h1 << i}, c);
      c = {i[1:0], i[0], 3'b000, 4'h1 << i};
      settle();
      chk({8'h0, sel, mgr, stop, gate}, {8'h0, i[1:0], ~i[0], 1'b0, 4'h1 << i});
    end
    @(posedge ref_clk_i);
    fraw <= '1;
    settle();
    chk({9'h0, doe, dpin, stop, gate}, 16'h0048);
    acc(4'hF, 1'b1, 10'h040, 10'h388);
    settle();
    chk({9'h0, doe, dpin, stop, gate}, 16'h0050);
    // temperature and pulsed pin sources, with the direct gate pins driven
    @(posedge ref_clk_i);
    gcmd <= 4'h6;
    acc(4'hF, 1'b1, 10'h200, 10'h040);
    settle();
    chk({9'h0, doe, dpin, stop, gate}, 16'h0066);
    acc(4'hF, 1'b1, 10'h100, 10'h200);
    settle();
    p = dpin;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk({15'h0, dpin}, {15'h0, ~p});
    stop_test();
  end
endmodule // tb_top
